// ---- verilog/mbr_pkg.sv ----
/*
   constants and carrier types of the modbus read master.
   assumes apb with 12-bit byte addresses and 32-bit data.
*/
package mbr_pkg;
   // register byte offsets
   localparam logic [11:0] A_CTRL  = 12'h000;
   localparam logic [11:0] A_REQ   = 12'h004;
   localparam logic [11:0] A_TMO   = 12'h008;
   localparam logic [11:0] A_STAT  = 12'h00c;
   localparam logic [11:0] A_MASK  = 12'h010;
   localparam logic [11:0] A_ECODE = 12'h014;
   localparam logic [11:0] A_CONV  = 12'h040;
   localparam logic [11:0] A_RXB   = 12'h100;
   // control fields
   localparam int C_SEND = 0;
   localparam int C_RTU  = 1;
   // status and mask fields
   localparam int S_REPLY = 0;
   localparam int S_ADDR  = 1;
   localparam int S_TMO   = 2;
   localparam int S_DONE  = 3;
   localparam int S_PARAM = 4;
   localparam int NSTAT   = 5;
   // protocol values
   localparam logic [7:0]  FUNC_RD   = 8'h03;
   localparam logic [7:0]  FUNC_EXC  = 8'h83;
   localparam logic [7:0]  EXC_ADDR  = 8'h02;
   localparam logic [7:0]  NODE_MAX  = 8'hfe;
   localparam logic [7:0]  CNT_MIN   = 8'h02;
   localparam logic [7:0]  CNT_MAX   = 8'h06;
   localparam logic [7:0]  DATA_MAX  = 8'h0c;
   localparam logic [7:0]  HDR_LEN   = 8'h03;
   localparam logic [7:0]  CRC_LEN   = 8'h02;
   localparam logic [7:0]  LRC_LEN   = 8'h01;
   localparam logic [7:0]  BN_MAX    = 8'h14;
   localparam logic [4:0]  LEN_RTU   = 5'h08;
   localparam logic [4:0]  LEN_ASC   = 5'h11;
   localparam logic [15:0] CRC_INIT  = 16'hffff;
   localparam logic [15:0] CRC_POLY  = 16'ha001;
   // characters
   localparam logic [7:0]  CH_COLON  = 8'h3a;
   localparam logic [7:0]  CH_CR     = 8'h0d;
   localparam logic [7:0]  CH_LF     = 8'h0a;
   localparam logic [7:0]  CH_ZERO   = 8'h30;
   localparam logic [7:0]  CH_NINE   = 8'h39;
   localparam logic [7:0]  CH_UA     = 8'h41;
   localparam logic [7:0]  CH_UF     = 8'h46;
   localparam logic [7:0]  CH_LOWA   = 8'h61;
   localparam logic [7:0]  CH_LOWF   = 8'h66;
   localparam logic [7:0]  HEX_ALPHA = 8'h37;
   // timing
   localparam int CLK_HZ  = 50_000_000;
   localparam int BAUD    = 9600;
   localparam int TMO_MS  = 10;
   localparam int BIT_DIV = CLK_HZ / BAUD;
   localparam int TMO_CYC = CLK_HZ / 1000 * TMO_MS;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_TX    = 3'b001,
      ST_DRAIN = 3'b010,
      ST_WAIT  = 3'b011,
      ST_RX    = 3'b100,
      ST_CHECK = 3'b101
   } mbr_state_t;

   typedef struct packed {
      logic [11:0] paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
   } mbr_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } mbr_apb_rsp_t;

   typedef struct packed {
      logic txd;
      logic de;
   } mbr_sp_t;
endpackage : mbr_pkg

// ---- verilog/mbr_crc.sv ----
/*
   one byte step of the modbus crc-16, reflected polynomial.
   assumes the caller holds the running value in a register or chains one step per byte.
*/
`timescale 1ns/10ps
module mbr_crc (
   // running value and next byte
   input  wire logic [15:0] crc_in,
   input  wire logic [7:0]  byte_in,
   // value after the byte
   output logic      [15:0] crc_out
);
   import mbr_pkg::*;

   always_comb begin
      crc_out = crc_in ^ {8'h00, byte_in};
      for (int i = 0; i < 8; i++) begin
         if (crc_out[0])
            crc_out = (crc_out >> 1) ^ CRC_POLY;
         else
            crc_out = crc_out >> 1;
      end
   end
endmodule : mbr_crc

// ---- verilog/mbr_uart.sv ----
/*
   8n1 byte serialiser and deserialiser for the serial port.
   assumes rxd is already synchronous to pclk.
*/
`timescale 1ns/10ps
module mbr_uart #(
   parameter int DIV = mbr_pkg::BIT_DIV
) (
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // transmit byte handshake
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output logic            tx_ready,
   output logic            tx_busy,
   // received byte strobe
   output logic            rx_valid,
   output logic [7:0]      rx_data,
   // line
   input  wire logic       rxd,
   output logic            txd
);
   import mbr_pkg::*;

   typedef struct packed {
      logic [15:0] tcnt;
      logic [3:0]  tbit;
      logic [9:0]  tsh;
      logic        tbusy;
      logic [15:0] rcnt;
      logic [3:0]  rbit;
      logic [7:0]  rsh;
      logic        rbusy;
      logic        rvalid;
      logic [7:0]  rdata;
   } mbr_uart_st_t;

   localparam logic [15:0] DIV16 = 16'(DIV);
   localparam mbr_uart_st_t RST = '{tsh: 10'h3ff, default: '0};

   mbr_uart_st_t s;
   mbr_uart_st_t n;

   always_comb begin
      n = s;
      n.rvalid = 1'b0;
      if (s.tbusy) begin
         if (s.tcnt == 16'h0) begin
            n.tcnt = DIV16 - 16'h1;
            n.tsh = {1'b1, s.tsh[9:1]};
            if (s.tbit == 4'h0)
               n.tbusy = 1'b0;
            else
               n.tbit = s.tbit - 4'h1;
         end else
            n.tcnt = s.tcnt - 16'h1;
      end else if (tx_valid) begin
         n.tbusy = 1'b1;
         n.tbit = 4'h9;
         n.tcnt = DIV16 - 16'h1;
         n.tsh = {1'b1, tx_data, 1'b0};
      end
      // receiver samples mid bit
      if (s.rbusy) begin
         if (s.rcnt == 16'h0) begin
            n.rcnt = DIV16 - 16'h1;
            n.rbit = s.rbit - 4'h1;
            if (s.rbit == 4'h9) begin
               if (rxd)
                  n.rbusy = 1'b0;
            end else if (s.rbit == 4'h0) begin
               n.rbusy = 1'b0;
               n.rvalid = rxd;
               n.rdata = s.rsh;
            end else
               n.rsh = {rxd, s.rsh[7:1]};
         end else
            n.rcnt = s.rcnt - 16'h1;
      end else if (!rxd) begin
         n.rbusy = 1'b1;
         n.rbit = 4'h9;
         n.rcnt = {1'b0, DIV16[15:1]};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         s <= RST;
      else
         s <= n;
   end

   assign tx_ready = !s.tbusy;
   assign tx_busy  = s.tbusy;
   assign txd      = s.tsh[0];
   assign rx_valid = s.rvalid;
   assign rx_data  = s.rdata;
endmodule : mbr_uart

// ---- verilog/mbr_read_master.sv ----
/*
   modbus read-holding-registers master with apb registers.
   assumes one apb master and a slave node on the rs-485 port.
*/
`timescale 1ns/10ps
module mbr_read_master #(
   parameter logic [23:0] TMO_DEF   = 24'(mbr_pkg::TMO_CYC),
   parameter int          BIT_DIV_P = mbr_pkg::BIT_DIV,
   parameter int          RXD       = 40
) (
   // clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // apb slave
   input  wire mbr_pkg::mbr_apb_req_t apb_i,
   output      mbr_pkg::mbr_apb_rsp_t apb_o,
   // second serial port
   input  wire logic                  sp2_rxd,
   output      mbr_pkg::mbr_sp_t      sp2_o,
   // interrupt
   output logic                       irq
);
   import mbr_pkg::*;

   typedef struct packed {
      mbr_state_t           st;
      logic                 send;
      logic                 rtu;
      logic [7:0]           node;
      logic [7:0]           cnt;
      logic [15:0]          sreg;
      logic [23:0]          tmo;
      logic [NSTAT-1:0]     stat;
      logic [NSTAT-1:0]     mask;
      logic [7:0]           ecode;
      logic [5:0][15:0]     conv;
      logic [RXD-1:0][7:0]  rxb;
      logic [4:0]           ti;
      logic [23:0]          tc;
      logic [5:0]           rc;
      logic [7:0]           bn;
      logic [7:0]           rnode;
      logic [7:0]           rfunc;
      logic [7:0]           rbc;
      logic [7:0]           sum;
      logic [15:0]          crc;
      logic                 hi;
      logic [3:0]           nib;
      logic                 bad;
      logic [31:0]          prdata;
      logic                 de;
   } mbr_st_t;

   localparam logic [5:0] RXD6 = 6'(RXD);
   localparam mbr_st_t RST = '{st: ST_IDLE, tmo: TMO_DEF, crc: CRC_INIT,
                               default: '0};

   mbr_st_t          s;
   mbr_st_t          n;
   logic             tx_valid;
   logic             tx_ready;
   logic             tx_busy;
   logic             rx_valid;
   logic [7:0]       tx_data;
   logic [7:0]       rx_data;
   logic [7:0]       rbyte;
   logic [4:0]       hv;
   logic [5:0][7:0]  tb;
   logic [6:0][15:0] crc_c;
   logic [15:0]      rx_crc;
   logic [7:0]       lrc;
   logic [7:0]       tsel;
   logic [4:0]       tk;
   logic [7:0]       wi;
   logic [7:0]       exp_len;
   logic             rt_end;
   logic             bv;
   logic             hit;
   logic [31:0]      rdat;
   logic             exc;
   logic             chk_ok;
   logic             len_ok;
   logic             base_ok;
   logic             good;

   function automatic logic [7:0] hexc(input logic [3:0] v);
      hexc = (v < 4'ha) ? CH_ZERO + {4'h0, v} : HEX_ALPHA + {4'h0, v};
   endfunction : hexc

   function automatic logic [4:0] hexv(input logic [7:0] c);
      hexv = 5'h00;
      if (c >= CH_ZERO && c <= CH_NINE)
         hexv = {1'b1, c[3:0]};
      else if ((c >= CH_UA && c <= CH_UF) || (c >= CH_LOWA && c <= CH_LOWF))
         hexv = {1'b1, c[3:0] + 4'h9};
   endfunction : hexv

   // request bytes: node, function, start hi/lo, count hi/lo
   assign tb = {s.cnt, 8'h00, s.sreg[7:0], s.sreg[15:8], FUNC_RD, s.node};

   always_comb begin
      lrc = 8'h00;
      for (int i = 0; i < 6; i++)
         lrc = lrc - tb[i];
   end

   assign crc_c[0] = CRC_INIT;
   for (genvar g = 0; g < 6; g++) begin : g_crc
      mbr_crc u_crc (
         .crc_in  (crc_c[g]),
         .byte_in (tb[g]),
         .crc_out (crc_c[g+1])
      );
   end

   // transmit character for index ti
   always_comb begin
      tk = s.ti - 5'h1;
      tsel = (tk[3:1] > 3'h5) ? lrc : tb[tk[3:1]];
      if (s.rtu) begin
         if (s.ti < 5'h6)
            tx_data = tb[s.ti[2:0]];
         else if (s.ti == 5'h6)
            tx_data = crc_c[6][7:0];
         else
            tx_data = crc_c[6][15:8];
      end else if (s.ti == 5'h0)
         tx_data = CH_COLON;
      else if (s.ti == LEN_ASC - 5'h2)
         tx_data = CH_CR;
      else if (s.ti == LEN_ASC - 5'h1)
         tx_data = CH_LF;
      else
         tx_data = hexc(tk[0] ? tsel[3:0] : tsel[7:4]);
   end

   assign hv = hexv(rx_data);
   assign rbyte = s.rtu ? rx_data : {s.nib, hv[3:0]};

   mbr_crc u_rx_crc (
      .crc_in  (s.crc),
      .byte_in (rbyte),
      .crc_out (rx_crc)
   );

   // rtu frame ends when the byte count field is satisfied
   assign exp_len = HDR_LEN + CRC_LEN +
                    (s.rfunc[7] ? 8'h00 : ((s.bn == 8'h2) ? rbyte : s.rbc));
   assign rt_end = s.rtu && s.bn >= 8'h2 && s.bn + 8'h1 == exp_len;

   // reply verdict
   assign exc = s.rfunc == FUNC_EXC;
   assign chk_ok = s.rtu ? (s.crc == 16'h0) : (s.sum == 8'h0);
   assign len_ok = s.bn == HDR_LEN + (exc ? 8'h00 : s.rbc) +
                   (s.rtu ? CRC_LEN : LRC_LEN);
   assign base_ok = !s.bad && !s.hi && chk_ok && len_ok &&
                    s.rnode == s.node;
   assign good = base_ok && s.rfunc == FUNC_RD &&
                 s.rbc == {s.cnt[6:0], 1'b0};

   always_comb begin
      n = s;
      tx_valid = 1'b0;
      bv = 1'b0;
      wi = s.bn - HDR_LEN;
      hit = 1'b1;
      rdat = 32'h0;
      // read decode
      if (apb_i.paddr[11:8] == A_RXB[11:8] && apb_i.paddr[7:2] < RXD6)
         rdat = {24'h0, s.rxb[apb_i.paddr[7:2]]};
      else if (apb_i.paddr[11:5] == A_CONV[11:5] && apb_i.paddr[4:2] < 3'h6)
         rdat = {16'h0, s.conv[apb_i.paddr[4:2]]};
      else begin
         case ({apb_i.paddr[11:2], 2'b00})
            A_CTRL:  rdat = {29'h0, s.st != ST_IDLE, s.rtu, s.send};
            A_REQ:   rdat = {s.sreg, s.cnt, s.node};
            A_TMO:   rdat = {8'h0, s.tmo};
            A_STAT:  rdat = {27'h0, s.stat};
            A_MASK:  rdat = {27'h0, s.mask};
            A_ECODE: rdat = {24'h0, s.ecode};
            default: hit = 1'b0;
         endcase
      end
      if (apb_i.psel && !apb_i.penable)
         n.prdata = rdat;
      // writes land in the access phase
      if (apb_i.psel && apb_i.penable && apb_i.pwrite) begin
         case ({apb_i.paddr[11:2], 2'b00})
            A_CTRL: begin
               if (s.st == ST_IDLE) begin
                  n.send = apb_i.pwdata[C_SEND];
                  n.rtu = apb_i.pwdata[C_RTU];
               end
            end
            A_REQ: begin
               if (s.st == ST_IDLE)
                  {n.sreg, n.cnt, n.node} = apb_i.pwdata;
            end
            A_TMO:   n.tmo = apb_i.pwdata[23:0];
            A_STAT:  n.stat = s.stat & ~apb_i.pwdata[NSTAT-1:0];
            A_MASK:  n.mask = apb_i.pwdata[NSTAT-1:0];
            default: ;
         endcase
      end
      // hardware events after software clears, so a set wins
      case (s.st)
         ST_IDLE: begin
            if (s.send) begin
               n.send = 1'b0;
               if (s.node > NODE_MAX || s.cnt < CNT_MIN || s.cnt > CNT_MAX)
                  n.stat[S_PARAM] = 1'b1;
               else begin
                  n.st = ST_TX;
                  n.ti = 5'h0;
                  n.rc = 6'h0;
                  n.bn = 8'h0;
                  n.crc = CRC_INIT;
                  n.sum = 8'h0;
                  n.hi = 1'b0;
                  n.bad = 1'b0;
               end
            end
         end
         ST_TX: begin
            tx_valid = 1'b1;
            if (tx_ready) begin
               n.ti = s.ti + 5'h1;
               if (s.ti == (s.rtu ? LEN_RTU : LEN_ASC) - 5'h1)
                  n.st = ST_DRAIN;
            end
         end
         ST_DRAIN: begin
            if (!tx_busy) begin
               n.st = ST_WAIT;
               n.tc = s.tmo;
            end
         end
         ST_WAIT, ST_RX: begin
            if (rx_valid) begin
               n.st = ST_RX;
               n.tc = s.tmo;
               if (s.rc < RXD6) begin
                  n.rxb[s.rc] = rx_data;
                  n.rc = s.rc + 6'h1;
               end
               if (s.rtu)
                  bv = 1'b1;
               else if (rx_data == CH_COLON) begin
                  n.bn = 8'h0;
                  n.sum = 8'h0;
                  n.hi = 1'b0;
                  n.bad = 1'b0;
               end else if (rx_data == CH_LF)
                  n.st = ST_CHECK;
               else if (rx_data != CH_CR) begin
                  if (!hv[4])
                     n.bad = 1'b1;
                  else if (!s.hi) begin
                     n.hi = 1'b1;
                     n.nib = hv[3:0];
                  end else begin
                     n.hi = 1'b0;
                     bv = 1'b1;
                  end
               end
               if (bv) begin
                  if (s.bn >= BN_MAX)
                     n.bad = 1'b1;
                  else begin
                     n.bn = s.bn + 8'h1;
                     n.sum = s.sum + rbyte;
                     n.crc = rx_crc;
                     case (s.bn)
                        8'h0:    n.rnode = rbyte;
                        8'h1:    n.rfunc = rbyte;
                        8'h2:    n.rbc = rbyte;
                        default: ;
                     endcase
                     // ascii data bytes pack into words, high byte first
                     if (!s.rtu && s.rfunc == FUNC_RD && s.bn >= HDR_LEN &&
                         wi < s.rbc && wi < DATA_MAX) begin
                        if (wi[0])
                           n.conv[wi[3:1]][7:0] = rbyte;
                        else
                           n.conv[wi[3:1]][15:8] = rbyte;
                     end
                     if (rt_end)
                        n.st = ST_CHECK;
                  end
               end
            end else if (s.tc == 24'h0) begin
               if (s.st == ST_WAIT) begin
                  n.stat[S_TMO] = 1'b1;
                  n.st = ST_IDLE;
               end else
                  n.st = ST_CHECK;
            end else
               n.tc = s.tc - 24'h1;
         end
         ST_CHECK: begin
            n.st = ST_IDLE;
            if (good) begin
               n.stat[S_REPLY] = 1'b0;
               n.stat[S_ADDR] = 1'b0;
               n.stat[S_DONE] = 1'b1;
            end else if (base_ok && exc) begin
               n.ecode = s.rbc;
               if (s.rbc == EXC_ADDR)
                  n.stat[S_ADDR] = 1'b1;
               else
                  n.stat[S_REPLY] = 1'b1;
            end else
               n.stat[S_REPLY] = 1'b1;
         end
         default: n.st = ST_IDLE;
      endcase
      // driver enable covers the whole request frame
      n.de = n.st == ST_TX || n.st == ST_DRAIN;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         s <= RST;
      else
         s <= n;
   end

   mbr_uart #(
      .DIV (BIT_DIV_P)
   ) u_uart (
      .pclk     (pclk),
      .presetn  (presetn),
      .tx_valid (tx_valid),
      .tx_data  (tx_data),
      .tx_ready (tx_ready),
      .tx_busy  (tx_busy),
      .rx_valid (rx_valid),
      .rx_data  (rx_data),
      .rxd      (sp2_rxd),
      .txd      (sp2_o.txd)
   );

   assign sp2_o.de       = s.de;
   assign apb_o.prdata   = s.prdata;
   assign apb_o.pready   = 1'b1;
   assign apb_o.pslverr  = apb_i.psel && apb_i.penable && !hit;
   assign irq            = |(s.stat & s.mask);

   node_range_a: assert property (@(posedge pclk) disable iff (!presetn)
      s.st == ST_IDLE && s.send && s.node > NODE_MAX
      |=> s.st == ST_IDLE && s.stat[S_PARAM])
      else $error("bad node address was not refused");

   cnt_range_a: assert property (@(posedge pclk) disable iff (!presetn)
      s.st == ST_IDLE && s.send && s.node <= NODE_MAX &&
      (s.cnt < CNT_MIN || s.cnt > CNT_MAX)
      |=> s.st == ST_IDLE && s.stat[S_PARAM])
      else $error("bad register count was not refused");

   frame_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
      s.st == ST_TX && s.ti == 5'h0
      |-> tx_valid && tx_data == (s.rtu ? s.node : CH_COLON))
      else $error("first character does not match framing mode");

   func_code_a: assert property (@(posedge pclk) disable iff (!presetn)
      s.st == ST_TX && s.rtu && s.ti == 5'h1 |-> tx_data == FUNC_RD)
      else $error("function code is not 03");

   addr_exc_a: assert property (@(posedge pclk) disable iff (!presetn)
      s.st == ST_CHECK && base_ok && exc && s.rbc == EXC_ADDR
      |=> s.stat[S_ADDR] && s.ecode == EXC_ADDR && s.st == ST_IDLE)
      else $error("illegal address exception not recorded");

   rx_store_a: assert property (@(posedge pclk) disable iff (!presetn)
      rx_valid && (s.st == ST_WAIT || s.st == ST_RX) && s.rc < RXD6
      |=> s.rxb[$past(s.rc)] == $past(rx_data) &&
          s.rc == $past(s.rc) + 6'h1)
      else $error("received character not stored");

   good_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      s.st == ST_CHECK && good
      |=> !s.stat[S_REPLY] && !s.stat[S_ADDR] && s.stat[S_DONE])
      else $error("good reply did not clear error flags");

   tmo_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      s.st == ST_WAIT && s.tc == 24'h0 && !rx_valid
      |=> s.stat[S_TMO] && s.st == ST_IDLE)
      else $error("timeout flag not set on expiry");

   tmo_start_a: assert property (@(posedge pclk) disable iff (!presetn)
      s.st == ST_DRAIN && !tx_busy
      |=> s.st == ST_WAIT && s.tc == $past(s.tmo))
      else $error("timeout count not loaded after last character");
endmodule : mbr_read_master

// ---- dv/mbr_slave.sv ----
/*
   behavioural slave node on the rs-485 port: takes an rtu or ascii
   request, answers with data, an illegal-address exception or nothing.
   assumes 8n1 framing at DIV clocks per bit and that txd idles high.
*/
`timescale 1ns/10ps
module mbr_slave #(
   parameter int DIV = 8
) (
   // clock and line
   input  wire logic       pclk,
   input  wire logic       txd,
   input  wire logic       de,
   // reply kind: 0 data, 1 exception, 2 silent, 3 ascii data
   input  wire logic [1:0] mode,
   output logic            rxd
);
   logic [7:0]  rq[$];
   logic [7:0]  rp[$];
   logic [7:0]  b;
   logic [15:0] c;
   logic [7:0]  nd;
   logic [7:0]  ct;

   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] r;
      r = 16'hffff;
      foreach (q[i]) begin
         r ^= {8'h00, q[i]};
         repeat (8) r = r[0] ? (r >> 1) ^ 16'ha001 : r >> 1;
      end
      return r;
   endfunction : crc16

   function automatic logic [3:0] hx(input logic [7:0] ch);
      return (ch > 8'h39) ? ch[3:0] + 4'h9 : ch[3:0];
   endfunction : hx

   function automatic logic [7:0] hc(input logic [3:0] v);
      return (v > 4'h9) ? 8'h37 + {4'h0, v} : 8'h30 + {4'h0, v};
   endfunction : hc

   task automatic get(output logic [7:0] v);
      @(negedge txd);
      repeat (DIV / 2) @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
         repeat (DIV) @(posedge pclk);
         v[i] = txd;
      end
      repeat (DIV) @(posedge pclk);
   endtask : get

   task automatic put(input logic [7:0] v);
      rxd <= 1'b0;
      repeat (DIV) @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
         rxd <= v[i];
         repeat (DIV) @(posedge pclk);
      end
      rxd <= 1'b1;
      repeat (DIV) @(posedge pclk);
   endtask : put

   // line biased high while nobody drives it
   initial begin
      rxd = 1'b1;
      forever begin
         // frame length follows the mode in force while it arrives
         do begin
            get(b);
            rq.push_back(b);
         end while (rq.size() < ((mode == 2'd3) ? 17 : 8));
         nd = (mode == 2'd3) ? {hx(rq[1]), hx(rq[2])} : rq[0];
         ct = (mode == 2'd3) ? {hx(rq[11]), hx(rq[12])} : rq[5];
         wait (de === 1'b0);
         repeat (4 * DIV) @(posedge pclk);
         if (mode == 2'd1) begin
            rp = '{nd, 8'h83, 8'h02};
         end
         else begin
            rp = '{nd, 8'h03, 8'(2 * ct)};
            for (int i = 0; i < 2 * ct; i++) rp.push_back(8'(i * 37 + 23));
         end
         if (mode == 2'd3) begin
            b = 8'h00;
            foreach (rp[i]) b -= rp[i];
            rp.push_back(b);
            put(8'h3a);
            foreach (rp[i]) begin
               put(hc(rp[i][7:4]));
               put(hc(rp[i][3:0]));
            end
            put(8'h0d);
            put(8'h0a);
         end
         else begin
            c = crc16(rp);
            rp.push_back(c[7:0]);
            rp.push_back(c[15:8]);
            if (mode != 2'd2) foreach (rp[i]) put(rp[i]);
         end
      end
   end
endmodule : mbr_slave

// ---- dv/tb.sv ----
/*
   self-checking bench of the modbus read master over apb.
   assumes the slave model on the serial port and shortened counts.
*/
`timescale 1ns/10ps
module tb;
   import mbr_pkg::*;
   logic         pclk, presetn, irq, rxd, err;
   mbr_apb_req_t req;
   mbr_apb_rsp_t rsp;
   mbr_sp_t      sp;
   logic [1:0]   mode;
   logic [31:0]  rd, rnd;
   logic [4:0]   es;
   int           fails, samples_checked;

   mbr_read_master #(.TMO_DEF(24'd2000), .BIT_DIV_P(8)) mbr_read_master_i (
      .pclk(pclk), .presetn(presetn), .apb_i(req), .apb_o(rsp),
      .sp2_rxd(rxd), .sp2_o(sp), .irq(irq));
   mbr_slave #(.DIV(8)) mbr_slave_i (
      .pclk(pclk), .txd(sp.txd), .de(sp.de), .mode(mode), .rxd(rxd));

   always #10 pclk = ~pclk;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] s);
      samples_checked++;
      if (s !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   task automatic apb(input logic [11:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] r);
      @(posedge pclk);
      req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
      @(posedge pclk);
      req.penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (rsp.pready !== 1'b1);
      r = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb

   task automatic xact(input logic [7:0] nd, input logic [7:0] cnt,
                       input logic [1:0] m, input logic [4:0] st);
      logic [7:0]  ex[$];
      logic [15:0] c;
      logic [7:0]  ac[$];
      logic [7:0]  l;
      int          n;
      n = 0;
      mode = m;
      mbr_slave_i.rq.delete();
      apb(A_REQ, 1'b1, {rnd[31:16], cnt, nd}, rd);
      apb(A_CTRL, 1'b1, {30'h0, m != 2'd3, 1'b1}, rd);
      do begin
         apb(A_CTRL, 1'b0, 32'h0, rd);
         n++;
      end while (rd[2] !== 1'b0 || n < 3);
      es = (st == 5'h08) ? ((es & 5'h1c) | st) : (es | st);
      apb(A_STAT, 1'b0, 32'h0, rd);
      chk("stat", {27'h0, es}, rd);
      if (st == 5'h10) begin
         chk("frames", 32'h0, 32'(mbr_slave_i.rq.size()));
      end
      else begin
         ex = '{nd, 8'h03, rnd[31:24], rnd[23:16], 8'h00, cnt};
         if (m == 2'd3) begin
            l = 8'h00;
            foreach (ex[i]) l -= ex[i];
            ex.push_back(l);
            ac.push_back(8'h3a);
            foreach (ex[i]) begin
               ac.push_back(mbr_slave_i.hc(ex[i][7:4]));
               ac.push_back(mbr_slave_i.hc(ex[i][3:0]));
            end
            ex = ac;
            ex.push_back(8'h0d);
            ex.push_back(8'h0a);
         end
         else begin
            c = mbr_slave_i.crc16(ex);
            ex.push_back(c[7:0]);
            ex.push_back(c[15:8]);
         end
         chk("tx length", ex.size(), mbr_slave_i.rq.size());
         foreach (ex[i]) chk("tx byte", ex[i], mbr_slave_i.rq[i]);
      end
      if (m == 2'd1) begin
         apb(A_ECODE, 1'b0, 32'h0, rd);
         chk("ecode", 32'h2, rd);
      end
      if (st == 5'h08 && m != 2'd3) begin
         apb(A_RXB + 12'h008, 1'b0, 32'h0, rd);
         chk("byte count", {23'h0, cnt, 1'b0}, rd);
      end
      if (m == 2'd3) begin
         for (int k = 0; k < cnt; k++) begin
            apb(A_CONV + 12'(4 * k), 1'b0, 32'h0, rd);
            chk("conv", {16'h0, 8'(74*k+23), 8'(74*k+60)}, rd);
         end
      end
      $display("end of read node %0d count %0d", nd, cnt);
   endtask : xact

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict

   initial begin
      #2_000_000;
      fails++;
      print_verdict();
   end

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      req = '0;
      mode = 2'd0;
      rnd = 32'hb49af524;
      es = 5'h00;
      fails = 0;
      samples_checked = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(A_TMO, 1'b0, 32'h0, rd);
      chk("tmo reset", 32'd2000, rd);
      apb(12'h800, 1'b0, 32'h0, rd);
      chk("unmapped err", 32'h1, {31'h0, err});
      apb(A_MASK, 1'b1, 32'h4, rd);
      rnd = lfsr(rnd);
      xact(8'(rnd % 255), 8'd2, 2'd0, 5'h08);
      rnd = lfsr(rnd);
      xact(8'(rnd % 255), 8'd6, 2'd1, 5'h02);
      rnd = lfsr(rnd);
      xact(8'(rnd % 255), 8'd6, 2'd0, 5'h08);
      rnd = lfsr(rnd);
      xact(8'(rnd % 255), 8'd3, 2'd3, 5'h08);
      xact(8'(rnd % 255), 8'd7, 2'd0, 5'h10);
      xact(8'(rnd % 255), 8'd1, 2'd0, 5'h10);
      xact(8'hff, 8'd2, 2'd0, 5'h10);
      chk("irq quiet", 32'h0, {31'h0, irq});
      rnd = lfsr(rnd);
      xact(8'(rnd % 255), 8'd3, 2'd2, 5'h04);
      chk("irq set", 32'h1, {31'h0, irq});
      apb(A_STAT, 1'b1, 32'h1f, rd);
      @(posedge pclk);
      chk("irq clear", 32'h0, {31'h0, irq});
      print_verdict();
   end
endmodule : tb
